// file: hdl/rst_seq_pkg.sv
/*
 reset sequencer package: timing constants, phase enum, carrier structs.
 assumes a 100 MHz system clock.
*/
package rst_seq_pkg;
    localparam int          CLK_HZ           = 100_000_000;
    localparam int          RESET_LOW_MIN_US = 10;
    localparam int          RESET_LOW_MIN_CY =
        (RESET_LOW_MIN_US * (CLK_HZ / 1_000_000) > 0) ?
        RESET_LOW_MIN_US * (CLK_HZ / 1_000_000) : 1;
    localparam int          EXIT_DELAY_US    = 1000;
    localparam int          EXIT_DELAY_CY    = EXIT_DELAY_US / 2 *
                                               (CLK_HZ / 1_000_000);
    localparam int          INIT_MS          = 20;
    localparam int          INIT_CY          = INIT_MS * (CLK_HZ / 1000);
    localparam logic [6:0]  DEFAULT_ADDR     = 7'h7e;
    localparam logic [3:0]  ADDR_BIN_SHORT   = 4'h0;
    localparam logic [3:0]  ADDR_BIN_OPEN    = 4'hf;
    localparam logic [3:0]  ADDR_BIN_MULT    = 4'hc;
    localparam int          GPIO_W           = 26;
    localparam int          FAST_PIN_W       = 8;
    localparam int          CFG_W            = 32;
    localparam int          CFG_AW           = 4;

    typedef enum logic [2:0] {
        PH_RESET   = 3'b000,
        PH_EXIT    = 3'b001,
        PH_INIT    = 3'b010,
        PH_RUN     = 3'b011
    } phase_e;

    typedef struct packed {
        logic              wr;
        logic [CFG_AW-1:0] addr;
        logic [CFG_W-1:0]  data;
        logic              commit;
    } host_cmd_s;

    typedef struct packed {
        logic              wr;
        logic [CFG_AW-1:0] addr;
        logic [CFG_W-1:0]  data;
    } nv_wr_s;
endpackage

// file: hdl/reset_init_config_control.sv
/*
 reset, initialization and configuration commit control.
 assumes inputs synchronous to SYS_CLK; the nonvolatile store accepts one
 word per cycle while NV_WR.wr is high.
*/
// Behaviour
// - with the default bus address the test port is enabled and its shared pins are withheld from general use.
// - a shorted or open address-select pin forces the default bus address.
// - the device stays in reset until the supply detector reports the digital supply rail above the reset threshold.
// - a held low reset input keeps the device in reset once it exceeds the minimum low time.
// - after the reset input returns high the device leaves reset within a bounded delay.
// - every exit from reset starts a fixed-length initialization phase.
// - during initialization fast pulse pins drive low and all other general pins float.
// - after initialization normal operation follows the stored configuration.
// - the factory configuration floats general outputs, drives fast pulse pins low, disables sequencing and fault response.
// - a host parameter write changes only the matching working-memory word.
// - the commit command copies working memory into nonvolatile storage.
`timescale 1ns/1ps
`default_nettype none
module reset_init_config_control #(
    parameter int INIT_CYCLES = rst_seq_pkg::INIT_CY,
    parameter int EXIT_CYCLES = rst_seq_pkg::EXIT_DELAY_CY,
    parameter int DEPTH       = 1 << rst_seq_pkg::CFG_AW
) (
    input  wire logic                            SYS_CLK,
    input  wire logic                            RST,
    input  wire logic                            SUPPLY_ABOVE_THRESHOLD,
    input  wire logic                            RESET_IN_N,
    input  wire logic [3:0]                      ADDR_BIN_HI,
    input  wire logic [3:0]                      ADDR_BIN_LO,
    input  wire rst_seq_pkg::host_cmd_s          HOST_CMD,
    input  wire logic [rst_seq_pkg::GPIO_W-1:0]  RUN_GPIO_OUT,
    input  wire logic [rst_seq_pkg::GPIO_W-1:0]  RUN_GPIO_OE,
    output logic                                 IN_RESET,
    output logic                                 IN_INIT,
    output logic                                 RUNNING,
    output logic [6:0]                           BUS_ADDR,
    output logic                                 TEST_PORT_EN,
    output logic [rst_seq_pkg::GPIO_W-1:0]       GPIO_OUT,
    output logic [rst_seq_pkg::GPIO_W-1:0]       GPIO_OE,
    output logic                                 SEQ_EN,
    output logic                                 FAULT_RESP_EN,
    output rst_seq_pkg::nv_wr_s                  NV_WR,
    output logic                                 COMMIT_BUSY
);
    import rst_seq_pkg::*;

    localparam int CW = $clog2(INIT_CYCLES + EXIT_CYCLES + 2);
    localparam int FW = $clog2(RESET_LOW_MIN_CY + 2);
    localparam logic [GPIO_W-1:0] FAST_MASK =
        {{(GPIO_W-FAST_PIN_W){1'b0}}, {FAST_PIN_W{1'b1}}};
    // test port pins sit above the fast pulse pins
    localparam logic [GPIO_W-1:0] JTAG_MASK =
        {{(GPIO_W-FAST_PIN_W-4){1'b0}}, 4'hf, {FAST_PIN_W{1'b0}}};
    localparam logic [CW-1:0] INIT_LAST = CW'(INIT_CYCLES - 1);
    localparam logic [CW-1:0] EXIT_LAST = CW'(EXIT_CYCLES - 1);
    localparam logic [FW-1:0] FILT_LAST = FW'(RESET_LOW_MIN_CY);
    localparam logic [CFG_AW-1:0] CFG_SEQ_IDX   = 4'h0;
    localparam logic [CFG_AW-1:0] CFG_GPIO_IDX  = 4'h1;

    phase_e                 phase_ff, nxt_phase;
    logic [CW-1:0]          cnt_ff, nxt_cnt;
    logic [FW-1:0]          low_cnt_ff, nxt_low_cnt;
    logic                   ext_rst_ff, nxt_ext_rst;
    logic [CFG_W-1:0]       ram_ff [DEPTH];
    logic [CFG_W-1:0]       nv_ff  [DEPTH];
    logic                   copy_ff;
    logic [CFG_AW-1:0]      copy_idx_ff;
    logic                   in_reset_ff, in_init_ff, running_ff;
    logic [6:0]             addr_ff;
    logic                   tport_ff;
    logic [GPIO_W-1:0]      gpio_out_ff, gpio_oe_ff;
    logic                   seq_en_ff, fault_en_ff;
    nv_wr_s                 nv_wr_ff;

    // filter: only a low lasting the full minimum time counts
    assign nxt_low_cnt = RESET_IN_N ? '0 :
                         (low_cnt_ff == FILT_LAST) ? low_cnt_ff :
                         low_cnt_ff + FW'(1);
    assign nxt_ext_rst = RESET_IN_N ? 1'b0 :
                         (low_cnt_ff == FILT_LAST) ? 1'b1 :
                         ext_rst_ff;

    wire hold_reset = !SUPPLY_ABOVE_THRESHOLD || ext_rst_ff;

    always_comb
    begin
        nxt_phase = phase_ff;
        nxt_cnt   = cnt_ff;
        if (hold_reset)
        begin
            nxt_phase = PH_RESET;
            nxt_cnt   = '0;
        end
        else
        begin
            unique case (phase_ff)
                PH_RESET:
                begin
                    nxt_phase = PH_EXIT;
                    nxt_cnt   = '0;
                end
                PH_EXIT:
                    if (cnt_ff == EXIT_LAST)
                    begin
                        nxt_phase = PH_INIT;
                        nxt_cnt   = '0;
                    end
                    else
                        nxt_cnt = cnt_ff + CW'(1);
                PH_INIT:
                    if (cnt_ff == INIT_LAST)
                    begin
                        nxt_phase = PH_RUN;
                        nxt_cnt   = '0;
                    end
                    else
                        nxt_cnt = cnt_ff + CW'(1);
                PH_RUN:
                    nxt_phase = PH_RUN;
                default:
                    nxt_phase = PH_RESET;
            endcase
        end
    end

    wire addr_bad = (ADDR_BIN_HI == ADDR_BIN_SHORT) ||
                    (ADDR_BIN_HI == ADDR_BIN_OPEN) ||
                    (ADDR_BIN_LO == ADDR_BIN_SHORT) ||
                    (ADDR_BIN_LO == ADDR_BIN_OPEN);
    // widen before the product so the upper bins do not wrap
    wire [7:0] addr_dec = (8'(ADDR_BIN_HI) * 8'(ADDR_BIN_MULT)) +
                          8'(ADDR_BIN_LO);
    wire [6:0] nxt_addr = addr_bad ? DEFAULT_ADDR : addr_dec[6:0];
    wire       nxt_tport = (nxt_addr == DEFAULT_ADDR);

    // factory image is all zero: floats, no sequencing, no fault response
    wire [CFG_W-1:0]  seq_word  = nv_ff[CFG_SEQ_IDX];
    wire [CFG_W-1:0]  gpio_word = nv_ff[CFG_GPIO_IDX];
    wire [GPIO_W-1:0] run_oe_cfg = RUN_GPIO_OE & gpio_word[GPIO_W-1:0]
                                   & ~(tport_ff ? JTAG_MASK : '0);
    wire [GPIO_W-1:0] nxt_gpio_oe =
        (nxt_phase == PH_RUN) ? (run_oe_cfg | FAST_MASK) : FAST_MASK;
    wire [GPIO_W-1:0] nxt_gpio_out =
        (nxt_phase == PH_RUN) ? (RUN_GPIO_OUT & run_oe_cfg) : '0;
    wire nxt_seq_en   = (nxt_phase == PH_RUN) && seq_word[0];
    wire nxt_fault_en = (nxt_phase == PH_RUN) && seq_word[1];
    wire host_ok = (phase_ff == PH_RUN) && !copy_ff;
    wire start_copy = host_ok && HOST_CMD.commit;
    wire last_copy = copy_ff && (copy_idx_ff == CFG_AW'(DEPTH - 1));

    wire nxt_in_reset = (nxt_phase == PH_RESET) || (nxt_phase == PH_EXIT);
    wire nxt_in_init  = (nxt_phase == PH_INIT);
    wire nxt_running  = (nxt_phase == PH_RUN);
    // address captured once per start-up, like the pin bias scan
    wire capture_addr = (phase_ff == PH_EXIT) && (nxt_phase == PH_INIT);

    // phase walk and its cycle counter
    always_ff @(posedge SYS_CLK or posedge RST)
    begin
        if (RST)
        begin
            phase_ff <= PH_RESET;
            cnt_ff   <= '0;
        end
        else
        begin
            phase_ff <= nxt_phase;
            cnt_ff   <= nxt_cnt;
        end
    end

    // reset input filter
    always_ff @(posedge SYS_CLK or posedge RST)
    begin
        if (RST)
        begin
            low_cnt_ff <= '0;
            ext_rst_ff <= 1'b0;
        end
        else
        begin
            low_cnt_ff <= nxt_low_cnt;
            ext_rst_ff <= nxt_ext_rst;
        end
    end

    // phase flags, registered so the pins see no decode glitches
    always_ff @(posedge SYS_CLK or posedge RST)
    begin
        if (RST)
        begin
            in_reset_ff <= 1'b1;
            in_init_ff  <= 1'b0;
            running_ff  <= 1'b0;
        end
        else
        begin
            in_reset_ff <= nxt_in_reset;
            in_init_ff  <= nxt_in_init;
            running_ff  <= nxt_running;
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST)
    begin
        if (RST)
        begin
            addr_ff  <= DEFAULT_ADDR;
            tport_ff <= 1'b1;
        end
        else if (capture_addr)
        begin
            addr_ff  <= nxt_addr;
            tport_ff <= nxt_tport;
        end
    end

    // pin drive follows the phase
    always_ff @(posedge SYS_CLK or posedge RST)
    begin
        if (RST)
        begin
            gpio_out_ff <= '0;
            gpio_oe_ff  <= FAST_MASK;
        end
        else
        begin
            gpio_out_ff <= nxt_gpio_out;
            gpio_oe_ff  <= nxt_gpio_oe;
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST)
    begin
        if (RST)
        begin
            seq_en_ff   <= 1'b0;
            fault_en_ff <= 1'b0;
        end
        else
        begin
            seq_en_ff   <= nxt_seq_en;
            fault_en_ff <= nxt_fault_en;
        end
    end

    // storage has no reset: contents survive device resets
    always_ff @(posedge SYS_CLK)
    begin
        if (host_ok && HOST_CMD.wr)
            ram_ff[HOST_CMD.addr] <= HOST_CMD.data;
        if (copy_ff)
            nv_ff[copy_idx_ff] <= ram_ff[copy_idx_ff];
    end

    always_ff @(posedge SYS_CLK or posedge RST)
    begin
        if (RST)
        begin
            copy_ff     <= 1'b0;
            copy_idx_ff <= '0;
        end
        else
        begin
            copy_ff     <= start_copy || (copy_ff && !last_copy);
            copy_idx_ff <= copy_ff ? copy_idx_ff + CFG_AW'(1) : '0;
        end
    end

    // copy stream toward the store, one word per cycle
    always_ff @(posedge SYS_CLK or posedge RST)
    begin
        if (RST)
            nv_wr_ff <= '0;
        else
        begin
            nv_wr_ff.wr   <= copy_ff;
            nv_wr_ff.addr <= copy_idx_ff;
            nv_wr_ff.data <= ram_ff[copy_idx_ff];
        end
    end

    assign IN_RESET      = in_reset_ff;
    assign IN_INIT       = in_init_ff;
    assign RUNNING       = running_ff;
    assign BUS_ADDR      = addr_ff;
    assign TEST_PORT_EN  = tport_ff;
    assign GPIO_OUT      = gpio_out_ff;
    assign GPIO_OE       = gpio_oe_ff;
    assign SEQ_EN        = seq_en_ff;
    assign FAULT_RESP_EN = fault_en_ff;
    assign NV_WR         = nv_wr_ff;
    assign COMMIT_BUSY   = copy_ff;
endmodule
`default_nettype wire

// file: tb/ext_reset_src.sv
/*
 external reset circuit: pulls RESET_IN_N low for a commanded count.
 assumes go is a one-cycle request from the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module ext_reset_src (
    input  wire logic        clk,
    input  wire logic        go,
    input  wire logic [11:0] len,
    output logic             rst_n
);
    logic [11:0] cnt_ff = 12'h0;
    // pull-up keeps the line high between pulses
    assign rst_n = (cnt_ff == 12'h0);
    always @(posedge clk)
        if (go)
            cnt_ff <= len;
        else if (cnt_ff != 12'h0)
            cnt_ff <= cnt_ff - 12'h1;
endmodule
`default_nettype wire

// file: tb/rst_seq_props.sv
/*
 assertion checker for the reset sequencer.
 sees the top ports only; bound to every instance.
*/
`timescale 1ns/1ps
`default_nettype none
module rst_seq_props #(
    parameter int INIT_CYCLES = 50
) (
    input wire logic                   SYS_CLK,
    input wire logic                   RST,
    input wire logic                   SUPPLY_ABOVE_THRESHOLD,
    input wire logic                   RESET_IN_N,
    input wire logic [3:0]             ADDR_BIN_HI,
    input wire logic [3:0]             ADDR_BIN_LO,
    input wire rst_seq_pkg::host_cmd_s HOST_CMD,
    input wire logic                   IN_RESET,
    input wire logic                   IN_INIT,
    input wire logic                   RUNNING,
    input wire logic [6:0]             BUS_ADDR,
    input wire logic                   TEST_PORT_EN,
    input wire logic [25:0]            GPIO_OUT,
    input wire logic [25:0]            GPIO_OE,
    input wire rst_seq_pkg::nv_wr_s    NV_WR,
    input wire logic                   COMMIT_BUSY
);
    import rst_seq_pkg::*;
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    logic [15:0] init_cnt_ff;
    always_ff @(posedge SYS_CLK or posedge RST)
        if (RST)
            init_cnt_ff <= 16'h0;
        else
            init_cnt_ff <= IN_INIT ? init_cnt_ff + 16'h1 : 16'h0;
    a_test_port_pins:
        assert property (RUNNING |-> TEST_PORT_EN == (BUS_ADDR == 7'h7e)
            && (!TEST_PORT_EN || GPIO_OE[11:8] == 4'h0)) else $error("test port");
    a_addr_fallback:
        assert property (RUNNING && (ADDR_BIN_HI inside {4'h0, 4'hf} ||
            ADDR_BIN_LO inside {4'h0, 4'hf}) |-> BUS_ADDR == 7'h7e)
        else $error("no default address");
    a_supply_reset:
        assert property (!SUPPLY_ABOVE_THRESHOLD |-> ##[1:2] IN_RESET)
        else $error("low supply not in reset");
    a_reset_hold:
        assert property (IN_RESET && !RESET_IN_N |=> IN_RESET)
        else $error("left reset while held");
    a_exit_bound:
        assert property ($rose(RESET_IN_N) && SUPPLY_ABOVE_THRESHOLD
            |-> ##[1:30] !IN_RESET) else $error("slow reset exit");
    a_init_entry:
        assert property ($fell(IN_RESET) |-> IN_INIT) else $error("no init");
    a_init_length:
        assert property ($fell(IN_INIT) && RUNNING
            |-> init_cnt_ff == INIT_CYCLES) else $error("init length");
    a_init_pins:
        assert property (IN_INIT |-> GPIO_OE == 26'hff && GPIO_OUT == 26'h0)
        else $error("init pin states");
    a_write_local:
        assert property (HOST_CMD.wr && !COMMIT_BUSY && !NV_WR.wr
            |=> !NV_WR.wr) else $error("write touched storage");
    a_commit_walk:
        assert property (HOST_CMD.commit && RUNNING && !COMMIT_BUSY |=>
            COMMIT_BUSY ##1 NV_WR.wr && NV_WR.addr == 4'h0)
        else $error("commit copy start");
endmodule
bind reset_init_config_control rst_seq_props #(
    .INIT_CYCLES(INIT_CYCLES)
) u_props (.*);
`default_nettype wire

// file: tb/reset_init_config_control_bench.sv
/*
 bench for the reset sequencer with short init and exit counts.
 assumes the reset source model drives RESET_IN_N.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin errors++; \
    $display("[ERR] %0t value mismatch", $time); end end
module reset_init_config_control_bench;
    import rst_seq_pkg::*;
    logic clk = 0, rst = 1, sup = 1, go = 0, rin_n, in_reset, in_init;
    logic running, tpe, seq_en, fault_en, busy;
    logic [3:0] hi = 4'h0, lo = 4'h0;
    logic [11:0] len = 12'h0;
    logic [6:0] addr;
    logic [25:0] gout, goe, rout = '0, roe = '1;
    host_cmd_s cmd = '0;
    nv_wr_s nv;
    int errors = 0, check_count = 0;
    initial forever #5 clk = ~clk;
    ext_reset_src u_src (.clk(clk), .go(go), .len(len), .rst_n(rin_n));
    reset_init_config_control #(.INIT_CYCLES(50), .EXIT_CYCLES(10)) DUT (
        .SYS_CLK(clk), .RST(rst), .SUPPLY_ABOVE_THRESHOLD(sup),
        .RESET_IN_N(rin_n), .ADDR_BIN_HI(hi), .ADDR_BIN_LO(lo),
        .HOST_CMD(cmd), .RUN_GPIO_OUT(rout), .RUN_GPIO_OE(roe),
        .IN_RESET(in_reset), .IN_INIT(in_init), .RUNNING(running),
        .BUS_ADDR(addr), .TEST_PORT_EN(tpe), .GPIO_OUT(gout), .GPIO_OE(goe),
        .SEQ_EN(seq_en), .FAULT_RESP_EN(fault_en), .NV_WR(nv),
        .COMMIT_BUSY(busy));
    task automatic report_and_stop();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic wait_hi(ref logic s);
        for (int i = 0; i < 300 && s !== 1'b1; i++)
            @(negedge clk);
        if (s !== 1'b1)
        begin
            errors++;
            report_and_stop();
        end
    endtask
    task automatic run_up();
        wait_hi(in_init);
        `CHK({goe, gout}, {26'hff, 26'h0})
        wait_hi(running);
    endtask
    task automatic commit_cfg(input logic [31:0] w0, input logic [31:0] w1);
        for (int i = 0; i < 16; i++)
        begin
            @(negedge clk);
            cmd = '{1'b1, 4'(i), i == 0 ? w0 : i == 1 ? w1 : 32'h0, 1'b0};
            `CHK(nv.wr, 1'b0)
        end
        @(negedge clk);
        cmd = '{1'b0, 4'h0, 32'h0, 1'b1};
        @(negedge clk);
        cmd = '0;
        @(negedge clk);
        `CHK(busy, 1'b1)
        for (int i = 0; i < 16; i++)
        begin
            `CHK(nv, {1'b1, 4'(i), i == 0 ? w0 : i == 1 ? w1 : 32'h0})
            @(negedge clk);
        end
        `CHK({busy, nv.wr}, 2'b00)
    endtask
    task automatic supply_cycle(input logic [3:0] h, input logic [3:0] l);
        @(negedge clk);
        sup = 1'b0;
        repeat (3) @(negedge clk);
        `CHK(in_reset, 1'b1)
        hi = h;
        lo = l;
        repeat (20) @(negedge clk);
        sup = 1'b1;
        run_up();
    endtask
    // long pulse must reset, a short one must be filtered out
    task automatic ext_reset(input logic [11:0] n, input logic hit);
        @(negedge clk);
        len = n;
        go = 1'b1;
        @(negedge clk);
        go = 1'b0;
        repeat (n - 2) @(negedge clk);
        `CHK(in_reset, hit)
        if (hit)
            run_up();
        else
        begin
            repeat (4) @(negedge clk);
            `CHK(running, 1'b1)
        end
    endtask
    initial
    begin
        repeat (4) @(negedge clk);
        rst = 1'b0;
        run_up();
        `CHK({addr, tpe, goe[11:8]}, {7'h7e, 1'b1, 4'h0})
        commit_cfg(32'h0, 32'h0);
        supply_cycle(4'h1, 4'h2);
        `CHK({addr, tpe}, {7'h0e, 1'b0})
        `CHK({seq_en, fault_en, goe}, {2'b00, 26'hff})
        commit_cfg(32'h3, 32'hffffffff);
        ext_reset(12'h064, 1'b0);
        ext_reset(12'h44c, 1'b1);
        `CHK({seq_en, fault_en, goe}, {2'b11, 26'h3ffffff})
        supply_cycle(4'hf, 4'h3);
        `CHK({addr, tpe}, {7'h7e, 1'b1})
        rout = '1;
        @(negedge clk);
        `CHK({goe, gout}, {26'h3fff0ff, 26'h3fff0ff})
        report_and_stop();
    end
endmodule
`default_nettype wire
